// file: include/wcd_pkg.sv
// shared constants, types and helpers for the watchdog command block
package wcd_pkg;
	// clock and self-test step timing
	localparam int CLK_HZ = 20000000;
	localparam int STEP_MS = 250;
	localparam int STEP_CYC = CLK_HZ / 1000 * STEP_MS;
	// ascii characters
	localparam logic [7:0] CH_DOLLAR = 8'h24;
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_BANG = 8'h21;
	localparam logic [7:0] CH_QM = 8'h3f;
	localparam logic [7:0] CH_X = 8'h58;
	localparam logic [7:0] CH_R = 8'h52;
	localparam logic [7:0] CH_E = 8'h45;
	localparam logic [7:0] CH_W = 8'h57;
	localparam logic [7:0] CH_S = 8'h53;
	localparam logic [7:0] CH_D = 8'h44;
	localparam logic [7:0] CH_0 = 8'h30;
	localparam logic [7:0] CH_9 = 8'h39;
	localparam logic [7:0] CH_A = 8'h41;
	localparam logic [7:0] CH_F = 8'h46;
	localparam logic [7:0] HEX_LETTER_OFS = 8'h37;
	// command lengths after the leading dollar, slot count and last slot
	localparam logic [3:0] LEN_STAT = 4'h3;
	localparam logic [3:0] LEN_RTMO = 4'h4;
	localparam logic [3:0] LEN_RSLOT = 4'h5;
	localparam logic [3:0] LEN_WSLOT = 4'h7;
	localparam logic [3:0] LEN_WCHAN = 4'ha;
	localparam logic [3:0] LEN_MAX = 4'hc;
	localparam int NSLOT = 4;
	localparam logic [3:0] SLOT_LAST = 4'h3;
	// per-slot error codes
	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ERR_SPAN = 8'h01;
	localparam logic [7:0] ERR_SELF = 8'h02;
	localparam logic [7:0] ERR_ZERO = 8'h04;
	localparam logic [7:0] ERR_DATA = 8'h08;
	localparam logic [7:0] ERR_CJR = 8'h10;
	localparam logic [7:0] ERR_EEP = 8'h20;
	// register byte offsets and reset values
	localparam logic [7:0] REG_ADDR = 8'h00;
	localparam logic [7:0] REG_TIMEOUT = 8'h04;
	localparam logic [7:0] REG_SLOTMASK = 8'h08;
	localparam logic [7:0] REG_INT_STAT = 8'h0c;
	localparam logic [7:0] REG_INT_MASK = 8'h10;
	localparam logic [7:0] REG_SELFTEST = 8'h14;
	localparam logic [7:0] ADDR_RST = 8'h01;
	localparam logic [15:0] TIMEOUT_RST = 16'h0000;
	localparam logic [7:0] SLOTMASK_RST = 8'h00;
	localparam logic [15:0] CHANMASK_RST = 16'h0000;
	// interrupt bits
	localparam int IRQ_OK = 0;
	localparam int IRQ_FAIL = 1;
	localparam int IRQ_ST = 2;
	localparam int NIRQ = 3;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} wcd_apb_req_t;
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} wcd_apb_rsp_t;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} wcd_chr_t;
	typedef struct packed {
		logic power_indicator;
		logic run;
		logic tx;
		logic rx;
	} wcd_led_t;
	typedef struct packed {
		logic checksum;
		logic eeprom;
		logic rs232;
		logic rs485;
	} wcd_fault_t;
	typedef struct packed {
		logic eep;
		logic cjr;
		logic data;
		logic zero;
		logic self;
		logic span;
	} wcd_slot_fault_t;
	function automatic logic [4:0] wcd_from_hex(input logic [7:0] c);
		logic [7:0] t;
		t = 8'h00;
		if (c >= CH_0 && c <= CH_9) begin
			t = c - CH_0;
			return {1'b1, t[3:0]};
		end
		if (c >= CH_A && c <= CH_F) begin
			t = c - HEX_LETTER_OFS;
			return {1'b1, t[3:0]};
		end
		return 5'h00;
	endfunction
	function automatic logic [7:0] wcd_to_hex(input logic [3:0] n);
		if (n < 4'ha)
			return CH_0 + {4'h0, n};
		return HEX_LETTER_OFS + {4'h0, n};
	endfunction
	function automatic logic [7:0] wcd_code(input wcd_slot_fault_t f);
		logic [7:0] c;
		c = ERR_NONE;
		if (f.span) c = c | ERR_SPAN;
		if (f.self) c = c | ERR_SELF;
		if (f.zero) c = c | ERR_ZERO;
		if (f.data) c = c | ERR_DATA;
		if (f.cjr) c = c | ERR_CJR;
		if (f.eep) c = c | ERR_EEP;
		return c;
	endfunction
endpackage

// file: design/wcd_top.sv
// watchdog command interpreter, slot diagnosis and self-test indicators
//
// Summary of operation
// [R1] read timeout replies bang, address, four digits
// [R2] write slot mask stores two digits, acknowledges
// [R3] read slot mask returns stored two digits
// [R4] write channel mask stores four digits per slot
// [R5] read channel mask returns that slot's mask
// [R6] power-on lights power, run, tx, rx, off
// [R7] pass repeats sequence; fail holds one indicator
// [R8] status reply gives eight digits, slots 0-3
// [R9] error codes 00 ok, 01..20 per fault
// [R10] status command accepted on both ports
// [R11] tx and rx indicators follow line traffic
// [R12] bad syntax or foreign address gets silence
// [R13] several faults report their codes ORed
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module wcd_top #(
	parameter int STEP_CYCLES = wcd_pkg::STEP_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// apb register port
	input wcd_pkg::wcd_apb_req_t apb_req,
	output wcd_pkg::wcd_apb_rsp_t apb_rsp,
	// received characters, port 0 rs232, port 1 rs485
	input wcd_pkg::wcd_chr_t rx232,
	input wcd_pkg::wcd_chr_t rx485,
	// transmitted characters
	output wcd_pkg::wcd_chr_t tx,
	output logic tx_port,
	input wire logic tx_ready,
	// diagnosis inputs
	input wcd_pkg::wcd_fault_t st_fault,
	input wcd_pkg::wcd_slot_fault_t [wcd_pkg::NSLOT-1:0] slot_fault,
	// indicators and interrupt
	output wcd_pkg::wcd_led_t led,
	output logic irq
);
	import wcd_pkg::*;

	typedef enum logic [1:0] {P_IDLE, P_RECV, P_DEC, P_SEND} wcd_pst_t;
	typedef enum logic [2:0] {S_SEQ1, S_OFF1, S_SEQ2, S_OFF2, S_RUN, S_FAIL} wcd_sst_t;

	wcd_pst_t pst_q;
	wcd_sst_t sst_q;
	logic [7:0] rbuf_q [LEN_MAX];
	logic [7:0] tbuf_q [LEN_MAX];
	logic [3:0] rlen_q;
	logic [3:0] tlen_q;
	logic [3:0] tidx_q;
	logic ovf_q;
	logic port_q;
	logic [7:0] addr_q;
	logic [15:0] tmo_q;
	logic [7:0] slot_mask_q;
	logic [15:0] chan_mask_q [NSLOT];
	logic [NIRQ-1:0] stat_q;
	logic [NIRQ-1:0] mask_q;
	logic [31:0] st_cnt_q;
	logic [1:0] st_step_q;
	wcd_apb_rsp_t rsp_q;
	wcd_chr_t tx_q;
	wcd_led_t led_q;
	logic irq_q;
	logic ev_ok;
	logic ev_fail;
	logic ev_st;

	// receive selection and decode terms
	wcd_chr_t rc;
	logic [4:0] h [LEN_MAX];
	logic a_ok, is_stat, is_rtmo, is_rslot, is_wslot, is_rchan, is_wchan;
	logic cmd_ok, slot_bad;
	logic [1:0] slot;
	logic [31:0] dv;
	logic [3:0] dn;
	always_comb begin
		rc = port_q ? rx485 : rx232;
		for (int k = 0; k < LEN_MAX; k++)
			h[k] = wcd_from_hex(rbuf_q[k]);
		slot = h[4][1:0];
		a_ok = h[0][4] && h[1][4] && {h[0][3:0], h[1][3:0]} == addr_q && !ovf_q;
		is_stat = rlen_q == LEN_STAT && rbuf_q[2] == CH_E;
		is_rtmo = rlen_q == LEN_RTMO && rbuf_q[2] == CH_X && rbuf_q[3] == CH_R;
		is_rslot = rlen_q == LEN_RSLOT && rbuf_q[2] == CH_X && rbuf_q[3] == CH_E
			&& rbuf_q[4] == CH_R;
		is_wslot = rlen_q == LEN_WSLOT && rbuf_q[2] == CH_X && rbuf_q[3] == CH_E
			&& rbuf_q[4] == CH_W && h[5][4] && h[6][4];
		is_rchan = rlen_q == LEN_RSLOT && rbuf_q[2] == CH_X && rbuf_q[3] == CH_S
			&& h[4][4];
		is_wchan = rlen_q == LEN_WCHAN && rbuf_q[2] == CH_X && rbuf_q[3] == CH_S
			&& h[4][4] && rbuf_q[5] == CH_D && h[6][4] && h[7][4] && h[8][4] && h[9][4];
		// [R12] silent unless well formed
		cmd_ok = a_ok && (is_stat || is_rtmo || is_rslot || is_wslot || is_rchan
			|| is_wchan);
		slot_bad = (is_rchan || is_wchan) && h[4][3:0] > SLOT_LAST;
		dv = 32'h0;
		dn = 4'h0;
		if (!slot_bad) begin
			// [R1] timeout digits
			if (is_rtmo) begin
				dv = {tmo_q, 16'h0};
				dn = 4'h4;
			end
			// [R3] slot mask digits
			if (is_rslot) begin
				dv = {slot_mask_q, 24'h0};
				dn = 4'h2;
			end
			// [R5] channel mask digits
			if (is_rchan) begin
				dv = {chan_mask_q[slot], 16'h0};
				dn = 4'h4;
			end
			// [R8] [R9] [R13] slot codes 0 to 3
			if (is_stat) begin
				dv = {wcd_code(slot_fault[0]), wcd_code(slot_fault[1]),
					wcd_code(slot_fault[2]), wcd_code(slot_fault[3])};
				dn = 4'h8;
			end
		end
	end

	// command framing and reply
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pst_q <= P_IDLE;
			rlen_q <= 4'h0;
			ovf_q <= 1'b0;
			port_q <= 1'b0;
			tlen_q <= 4'h0;
			tidx_q <= 4'h0;
			tx_q <= '0;
			for (int k = 0; k < LEN_MAX; k++) begin
				rbuf_q[k] <= 8'h00;
				tbuf_q[k] <= 8'h00;
			end
		end else begin
			case (pst_q)
				P_IDLE: begin
					rlen_q <= 4'h0;
					ovf_q <= 1'b0;
					// [R10] either port may open a frame
					if (rx232.valid && rx232.data == CH_DOLLAR) begin
						port_q <= 1'b0;
						pst_q <= P_RECV;
					end else if (rx485.valid && rx485.data == CH_DOLLAR) begin
						port_q <= 1'b1;
						pst_q <= P_RECV;
					end
				end
				P_RECV: begin
					if (rc.valid) begin
						if (rc.data == CH_CR) begin
							pst_q <= P_DEC;
						end else if (rlen_q == LEN_MAX) begin
							ovf_q <= 1'b1;
						end else begin
							rbuf_q[rlen_q] <= rc.data;
							rlen_q <= rlen_q + 4'h1;
						end
					end
				end
				P_DEC: begin
					if (cmd_ok) begin
						// [R2] bang or question, address echo
						tbuf_q[0] <= slot_bad ? CH_QM : CH_BANG;
						tbuf_q[1] <= rbuf_q[0];
						tbuf_q[2] <= rbuf_q[1];
						for (int k = 0; k < 8; k++)
							if (k < dn)
								tbuf_q[3+k] <= wcd_to_hex(dv[4*(7-k)+:4]);
						tbuf_q[3+dn] <= CH_CR;
						tlen_q <= dn + 4'h4;
						tidx_q <= 4'h0;
						pst_q <= P_SEND;
					end else begin
						pst_q <= P_IDLE;
					end
				end
				P_SEND: begin
					if (!tx_q.valid) begin
						tx_q.valid <= 1'b1;
						tx_q.data <= tbuf_q[tidx_q];
					end else if (tx_ready) begin
						tx_q.valid <= 1'b0;
						tidx_q <= tidx_q + 4'h1;
						if (tidx_q == tlen_q - 4'h1)
							pst_q <= P_IDLE;
					end
				end
				default: pst_q <= P_IDLE;
			endcase
		end
	end

	assign ev_ok = pst_q == P_DEC && cmd_ok && !slot_bad;
	assign ev_fail = pst_q == P_DEC && cmd_ok && slot_bad;

	// stored masks
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			slot_mask_q <= SLOTMASK_RST;
			for (int k = 0; k < NSLOT; k++)
				chan_mask_q[k] <= CHANMASK_RST;
		end else if (ev_ok) begin
			// [R2] slot mask store
			if (is_wslot)
				slot_mask_q <= {h[5][3:0], h[6][3:0]};
			// [R4] channel mask store
			if (is_wchan)
				chan_mask_q[slot] <= {h[6][3:0], h[7][3:0], h[8][3:0], h[9][3:0]};
		end
	end

	// self-test sequencer
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sst_q <= S_SEQ1;
			st_cnt_q <= 32'h0;
			st_step_q <= 2'h0;
		end else if (sst_q != S_RUN && sst_q != S_FAIL) begin
			if (st_cnt_q == STEP_CYCLES - 1) begin
				st_cnt_q <= 32'h0;
				st_step_q <= st_step_q + 2'h1;
				case (sst_q)
					S_SEQ1: if (st_step_q == 2'h3) sst_q <= S_OFF1;
					S_SEQ2: if (st_step_q == 2'h3) sst_q <= S_OFF2;
					// [R7] fault check after first pass
					S_OFF1: sst_q <= (|st_fault) ? S_FAIL : S_SEQ2;
					S_OFF2: sst_q <= S_RUN;
					default: sst_q <= S_FAIL;
				endcase
				if (sst_q == S_OFF1 || sst_q == S_OFF2)
					st_step_q <= 2'h0;
			end else begin
				st_cnt_q <= st_cnt_q + 32'h1;
			end
		end
	end

	assign ev_st = sst_q == S_OFF2 && st_cnt_q == STEP_CYCLES - 1;

	// indicators
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			led_q <= '0;
		end else begin
			case (sst_q)
				// [R6] one lamp per step
				S_SEQ1, S_SEQ2: led_q <= 4'h8 >> st_step_q;
				S_OFF1, S_OFF2: led_q <= '0;
				// [R11] traffic shown in operation
				S_RUN: led_q <= {1'b1, 1'b1, tx_q.valid, rx232.valid | rx485.valid};
				// [R7] one lamp names the fault
				S_FAIL: begin
					if (st_fault.checksum) led_q <= 4'h8;
					else if (st_fault.eeprom) led_q <= 4'h4;
					else if (st_fault.rs232) led_q <= 4'h2;
					else led_q <= 4'h1;
				end
				default: led_q <= '0;
			endcase
		end
	end

	// interrupt status and mask
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			stat_q <= '0;
			irq_q <= 1'b0;
		end else begin
			stat_q <= (stat_q & ~((apb_req.psel && apb_req.penable && apb_req.pwrite
				&& rsp_q.pready && apb_req.paddr == REG_INT_STAT) ?
				apb_req.pwdata[NIRQ-1:0] : '0)) | {ev_st, ev_fail, ev_ok};
			irq_q <= |(stat_q & mask_q);
		end
	end

	// apb slave, one wait state
	logic wr;
	assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite && rsp_q.pready;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rsp_q <= '0;
			addr_q <= ADDR_RST;
			tmo_q <= TIMEOUT_RST;
			mask_q <= '0;
		end else begin
			rsp_q.pready <= apb_req.psel && apb_req.penable && !rsp_q.pready;
			rsp_q.pslverr <= 1'b0;
			rsp_q.prdata <= 32'h0;
			if (apb_req.psel && apb_req.penable && !rsp_q.pready) begin
				case (apb_req.paddr)
					REG_ADDR: rsp_q.prdata <= {24'h0, addr_q};
					REG_TIMEOUT: rsp_q.prdata <= {16'h0, tmo_q};
					REG_SLOTMASK: rsp_q.prdata <= {24'h0, slot_mask_q};
					REG_INT_STAT: rsp_q.prdata <= {29'h0, stat_q};
					REG_INT_MASK: rsp_q.prdata <= {29'h0, mask_q};
					REG_SELFTEST: rsp_q.prdata <= {26'h0, sst_q == S_FAIL, sst_q == S_RUN,
						st_fault};
					default: rsp_q.pslverr <= 1'b1;
				endcase
			end
			if (wr && apb_req.paddr == REG_ADDR) addr_q <= apb_req.pwdata[7:0];
			if (wr && apb_req.paddr == REG_TIMEOUT) tmo_q <= apb_req.pwdata[15:0];
			if (wr && apb_req.paddr == REG_INT_MASK) mask_q <= apb_req.pwdata[NIRQ-1:0];
		end
	end

	assign apb_rsp = rsp_q;
	assign tx = tx_q;
	assign tx_port = port_q;
	assign led = led_q;
	assign irq = irq_q;

	sequence seq_dec;
		pst_q == P_DEC && cmd_ok;
	endsequence
	sequence seq_load;
		pst_q == P_SEND && tidx_q == 4'h0;
	endsequence

	AST_REPLY_HEAD: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
		seq_dec ##1 seq_load ##1 tx_q.valid |-> tx_q.data == CH_BANG || tx_q.data == CH_QM)
		else $error("reply does not open with bang or question mark");
	AST_TMO_LEN: assert property (@(posedge clk) disable iff (!rst_b) // [R1]
		seq_dec and is_rtmo && !slot_bad |=> tlen_q == 4'h8)
		else $error("timeout reply length wrong");
	AST_SLOT_STORE: assert property (@(posedge clk) disable iff (!rst_b) // [R2]
		ev_ok && is_wslot |=> slot_mask_q == $past({h[5][3:0], h[6][3:0]}))
		else $error("slot mask not stored");
	AST_RSLOT_LEN: assert property (@(posedge clk) disable iff (!rst_b) // [R3]
		seq_dec and is_rslot |=> tlen_q == 4'h6 && tbuf_q[5] == CH_CR)
		else $error("slot mask reply malformed");
	AST_CHAN_STORE: assert property (@(posedge clk) disable iff (!rst_b) // [R4]
		ev_ok && is_wchan |=> chan_mask_q[$past(slot)][3:0] == $past(h[9][3:0]))
		else $error("channel mask not stored");
	AST_BAD_SLOT: assert property (@(posedge clk) disable iff (!rst_b) // [R5]
		seq_dec and slot_bad |=> tbuf_q[0] == CH_QM && tlen_q == 4'h4)
		else $error("bad slot not refused");
	AST_SEQ_ORDER: assert property (@(posedge clk) disable iff (!rst_b) // [R6]
		sst_q == S_SEQ1 && st_step_q == 2'h1 |=> led_q == 4'h4)
		else $error("self-test lamp order wrong");
	AST_FAIL_HOLD: assert property (@(posedge clk) disable iff (!rst_b) // [R7]
		sst_q == S_FAIL && $past(sst_q) == S_FAIL && $stable(st_fault) |=> $stable(led_q))
		else $error("fault lamp not held");
	AST_STAT_LEN: assert property (@(posedge clk) disable iff (!rst_b) // [R8]
		seq_dec and is_stat |=> tlen_q == 4'hc && tbuf_q[11] == CH_CR)
		else $error("status reply length wrong");
	AST_SILENT: assert property (@(posedge clk) disable iff (!rst_b) // [R12]
		pst_q == P_DEC && !cmd_ok |=> pst_q == P_IDLE ##1 !tx_q.valid)
		else $error("reply to bad command");
	AST_TX_LED: assert property (@(posedge clk) disable iff (!rst_b) // [R11]
		sst_q == S_RUN && $past(sst_q) == S_RUN |-> led_q.tx == $past(tx_q.valid))
		else $error("tx lamp not following line");
endmodule // wcd_top

// file: tb/wcd_host.sv
// host model: sends ascii commands and sinks replies
`timescale 1ns/1ps
module wcd_host (
	// clock
	input wire logic clk,
	// command lines to the device
	output wcd_pkg::wcd_chr_t rx232,
	output wcd_pkg::wcd_chr_t rx485,
	// reply line from the device
	input wcd_pkg::wcd_chr_t tx,
	output logic tx_ready
);
	import wcd_pkg::*;
	int slow = 0;
	int hold = 0;
	logic [7:0] got[$];
	initial begin
		rx232 = '0;
		rx485 = '0;
		tx_ready = 1'b0;
	end
	task automatic send(input bit port, input string s);
		logic [7:0] c;
		for (int i = 0; i <= s.len(); i++) begin
			@(posedge clk);
			c = (i == s.len()) ? CH_CR : s[i];
			if (port) rx485 <= '{1'b1, c};
			else rx232 <= '{1'b1, c};
		end
		@(posedge clk);
		rx232 <= '{1'b0, ~rx232.data};
		rx485 <= '{1'b0, ~rx485.data};
	endtask
	// take each reply char, promptly or after slow cycles
	always @(posedge clk) begin
		if (tx.valid && tx_ready) begin
			got.push_back(tx.data);
			tx_ready <= 1'b0;
			hold = 0;
		end else if (tx.valid && hold++ >= slow)
			tx_ready <= 1'b1;
	end
endmodule // wcd_host

// file: tb/watchdog_cmd_and_diag_test.sv
// self-checking bench for the watchdog command block
`timescale 1ns/1ps
module watchdog_cmd_and_diag_test;
	import wcd_pkg::*;
	localparam int STEPS = 4;
	localparam logic [3:0] FAIL_SEQ[7] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h0, 4'h2, 4'h1};
	localparam logic [3:0] PASS_SEQ[11] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h0, 4'h8, 4'h4, 4'h2,
		4'h1, 4'h0, 4'hc};
	logic clk;
	logic rst_b;
	wcd_apb_req_t apb_req;
	wcd_apb_rsp_t apb_rsp;
	wcd_chr_t rx232;
	wcd_chr_t rx485;
	wcd_chr_t tx;
	logic tx_port;
	logic tx_ready;
	wcd_fault_t st_fault;
	wcd_slot_fault_t [NSLOT-1:0] slot_fault;
	wcd_led_t led;
	logic irq;
	logic [3:0] prev_led;
	logic [3:0] led_log[$];
	logic [31:0] q;
	logic err;
	bit led_tx_seen;
	bit led_rx_seen;
	int n_errors = 0;
	int checks = 0;
	int cyc = 0;
	wcd_top #(.STEP_CYCLES(STEPS)) uut (
		.clk(clk), .rst_b(rst_b), .apb_req(apb_req), .apb_rsp(apb_rsp),
		.rx232(rx232), .rx485(rx485), .tx(tx), .tx_port(tx_port), .tx_ready(tx_ready),
		.st_fault(st_fault), .slot_fault(slot_fault), .led(led), .irq(irq)
	);
	wcd_host host (.clk(clk), .rx232(rx232), .rx485(rx485), .tx(tx), .tx_ready(tx_ready));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// log indicator changes, cut a hang short
	always @(posedge clk) begin
		cyc++;
		if (led !== prev_led) led_log.push_back(led);
		prev_led = led;
		if (led.tx) led_tx_seen = 1;
		if (led.rx) led_rx_seen = 1;
		if (cyc == 30000) begin
			n_errors++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("errors=%0d checks=%0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		apb_req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge clk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (apb_rsp.pready !== 1'b1 && n < 50);
		if (n == 50) n_errors++;
		q = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req <= '0;
	endtask
	// empty exp means no reply expected
	task automatic cmd(input bit port, input string s, input string exp);
		int n;
		host.got.delete();
		host.send(port, s);
		repeat (200) begin
			@(posedge clk);
			if (host.got.size() > 0 && host.got[$] === CH_CR) break;
		end
		n = (exp.len() > 0) ? exp.len() + 1 : 0;
		chk(host.got.size(), n);
		foreach (host.got[i]) chk(host.got[i], (i < exp.len()) ? exp[i] : CH_CR);
		if (n > 0) chk(tx_port, port);
	endtask
	task automatic reset_run(input wcd_fault_t f);
		@(posedge clk);
		rst_b <= 1'b0;
		st_fault <= f;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		led_log.delete();
	endtask
	initial begin
		rst_b = 1'b0;
		apb_req = '0;
		st_fault = '0;
		slot_fault = '0;
		prev_led = 4'h0;
		reset_run(4'h3);
		repeat (6 * STEPS + 4) @(posedge clk);
		st_fault <= 4'h1;
		repeat (4) @(posedge clk);
		chk(led_log.size(), 7);
		foreach (led_log[i]) chk(led_log[i], FAIL_SEQ[i]);
		apb(0, REG_SELFTEST, 0);
		chk(q, 32'h21);
		reset_run(4'h0);
		repeat (11 * STEPS + 4) @(posedge clk);
		chk(led_log.size(), 11);
		foreach (led_log[i]) chk(led_log[i], PASS_SEQ[i]);
		apb(0, REG_SELFTEST, 0);
		chk(q, 32'h10);
		apb(0, REG_ADDR, 0);
		chk(q, ADDR_RST);
		apb(0, REG_TIMEOUT, 0);
		chk(q, TIMEOUT_RST);
		apb(0, 8'h40, 0);
		chk(err, 1);
		chk(q, 0);
		apb(0, REG_INT_STAT, 0);
		chk(q, 32'h4);
		chk(irq, 0);
		apb(1, REG_INT_STAT, 32'h7);
		apb(1, REG_INT_MASK, 32'h1);
		apb(1, REG_TIMEOUT, 32'h1234);
		led_tx_seen = 0;
		led_rx_seen = 0;
		cmd(0, "$01XR", "!011234");
		chk(irq, 1);
		chk({led_tx_seen, led_rx_seen}, 2'h3);
		apb(1, REG_INT_STAT, 32'h1);
		repeat (2) @(posedge clk);
		chk(irq, 0);
		host.slow = 3;
		cmd(1, "$01XEWA5", "!01");
		host.slow = 0;
		cmd(0, "$01XER", "!01A5");
		apb(0, REG_SLOTMASK, 0);
		chk(q, 32'ha5);
		cmd(1, "$01XS3D1F0C", "!01");
		cmd(0, "$01XS3", "!011F0C");
		cmd(0, "$01XS4", "?01");
		apb(0, REG_INT_STAT, 0);
		chk(q, 32'h3);
		chk(irq, 1);
		slot_fault <= {6'h3f, 6'h10, 6'h00, 6'h21};
		cmd(1, "$01E", "!012100103F");
		slot_fault <= {6'h08, 6'h04, 6'h02, 6'h20};
		cmd(0, "$01E", "!0120020408");
		cmd(0, "$02XR", "");
		cmd(0, "$01XEWG1", "");
		stop_test();
	end
endmodule // watchdog_cmd_and_diag_test
